// ### sist_defs.svh
// Constants of the sensor interface safety and self-test block.
// Assumes inclusion by bare name from every file that needs them.
`ifndef SIST_DEFS_SVH
`define SIST_DEFS_SVH

// Register byte offsets on the APB window
`define SIST_A_SET 8'h00
`define SIST_A_STAT 8'h04
`define SIST_A_CHAN 8'h08
`define SIST_A_RES 8'h0C
`define SIST_A_SR2 8'h10
`define SIST_A_CMD 8'h14
`define SIST_A_DAT1 8'h18
`define SIST_A_DAT2 8'h1C
// Slot identity table at 0x40..0x7C, picked by paddr[7:6]
`define SIST_A_SID_PAGE 2'h1

// Field positions of the setting register
`define SIST_B_LEVEL 10
`define SIST_B_SEL_HI 9
`define SIST_B_SEL_LO 5
`define SIST_B_GO_SLV 11
`define SIST_B_GO_MST 12
`define SIST_B_STOP 13
// Field positions of the command register
`define SIST_B_ENTER 0
`define SIST_B_LEAVE 1

// Output test selector codes
`define SIST_SEL_OUT1 5'h15
`define SIST_SEL_OUT2 5'h16

// Reset values and the empty code
`define SIST_CHAN_RST 9'h180
`define SIST_EMPTY 16'h01F0

// Timing: clock rate and test phase times
`define SIST_CLK_MHZ 20
`define SIST_T_LONG_US 512
`define SIST_T_SHORT_US 128
// Sync pulse lengths in clock cycles
`define SIST_PULSE_STD 8'h28
`define SIST_PULSE_LONG 8'h50

`endif

// ### sist_pkg.sv
// Types shared by the self-test block and its helpers.
// Assumes nothing of its surroundings.
package sist_pkg;
	// Cross-coupling test sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SLV_PD = 3'b001,
		ST_STB_ON = 3'b010,
		ST_STB_DIS = 3'b011,
		ST_X_ON = 3'b100,
		ST_X_DIS = 3'b101
	} sist_xct_state_t;
endpackage : sist_pkg

// ### sist_sid_if.sv
// Link between the self-test block and its slot identity memory.
// Assumes one clock shared by both ends.
`timescale 1ns/100ps
`default_nettype none
interface sist_sid_if;
	logic we; // Table write strobe
	logic [3:0] waddr; // Write word
	logic [4:0] wdata; // Identity to store
	logic [3:0] raddr; // Read word, {channel, slot}
	logic [4:0] rdata; // Registered read data
	modport mem (input we, input waddr, input wdata, input raddr,
		output rdata);
	modport user (output we, output waddr, output wdata, output raddr,
		input rdata);
endinterface : sist_sid_if
`default_nettype wire

// ### sist_sid_mem.sv
// Slot identity table, sixteen words of five bits.
// Assumes the user side drives the interface from pclk logic.
`timescale 1ns/100ps
`default_nettype none
module sist_sid_mem (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Table access
	sist_sid_if.mem m
);
	logic [4:0] ram [16]; // Identity words, no reset needed

	// Write port
	always_ff @(posedge pclk) begin
		if (m.we) begin
			ram[m.waddr] <= m.wdata;
		end
	end

	// Registered read port, one cycle behind the address
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			m.rdata <= 5'h00;
		end else begin
			m.rdata <= ram[m.raddr];
		end
	end
endmodule : sist_sid_mem
`default_nettype wire

// ### sist_sync_pulse.sv
// Sync pulse start and receiver freeze for one channel.
// Assumes trig_pin is asynchronous; other inputs are pclk logic.
`timescale 1ns/100ps
`default_nettype none
`include "sist_defs.svh"
module sist_sync_pulse (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Trigger sources
	input wire logic trig_pin,
	input wire logic ext_trig,
	// Configuration
	input wire logic pin_mode,
	input wire logic udb_en,
	input wire logic method_pw,
	input wire logic up_bit,
	// Pulse and freeze
	output logic pulse,
	output logic freeze
);
	logic meta; // First sync stage, read only by syn
	logic syn; // Second sync stage
	logic last; // Previous filtered level
	logic [7:0] cnt; // Pulse length down counter
	logic direct; // Pin trigger without upstream buffer
	logic rise; // Filtered pin rising edge
	logic trig; // Selected trigger
	logic skip; // Tooth gap zero: no pulse
	logic long_p; // Pulse width one: long pulse
	logic [7:0] len; // Chosen pulse length

	assign direct = pin_mode & ~udb_en;
	assign rise = syn & ~last;
	assign trig = direct ? rise : ext_trig;
	// Direct pin mode gives a standard pulse only; else encode here
	assign skip = ~direct & ~method_pw & ~up_bit; // RQ3
	assign long_p = ~direct & method_pw & up_bit; // RQ3
	assign len = long_p ? `SIST_PULSE_LONG : `SIST_PULSE_STD;
	// Receiver stays frozen for the whole pulse
	assign freeze = pulse; // RQ2

	// Pin synchroniser and edge memory
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta <= 1'b0;
			syn <= 1'b0;
			last <= 1'b0;
		end else begin
			meta <= trig_pin;
			syn <= meta;
			last <= syn;
		end
	end

	// Pulse timer; a trigger during a pulse is dropped until its last cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 8'h00;
			pulse <= 1'b0;
		end else if (trig && cnt == 8'h00 && !skip) begin
			cnt <= len - 8'h01; // RQ1
			pulse <= 1'b1; // RQ1
		end else if (cnt != 8'h00) begin
			cnt <= cnt - 8'h01;
		end else begin
			pulse <= 1'b0;
		end
	end

	AST_PIN_START: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
		(direct && rise && cnt == 8'h00) |=> pulse)
		else $error("pin edge did not start a pulse");
endmodule : sist_sync_pulse
`default_nettype wire

// ### sist_selftest.sv
// Safety and self-test logic of a two-channel sensor transceiver.
// Assumes an APB master on pclk, a decoder on pclk and async pins.
`timescale 1ns/100ps
`default_nettype none
`include "sist_defs.svh"
// Behaviour
// RQ1 - Pin mode starts pulse on filtered edge
// RQ2 - Receiver frozen throughout its sync pulse
// RQ3 - Pulse encoding by device unless direct pin
// RQ4 - Stored slot identity returned with diagnostic bit
// RQ5 - Data and identity written in one access
// RQ6 - Fault forcing accepted only in self-test mode
// RQ7 - Empty code written after read, then verified
// RQ8 - Buffer test bit keeps old data
// RQ9 - Level bit drives the selected output
// RQ10 - Selector codes pick output one or two
// RQ11 - Never two outputs in test mode
// RQ12 - Test starts only with both channels off
// RQ13 - Switch-on and supply-off ignored during test
// RQ14 - Stop bit aborts; flag only in master
// RQ15 - Running while busy, done at finish
// RQ16 - Results clear on read or start
// RQ17 - Status bits hold master ground-short results
// RQ18 - Slave pull-down 512 us, then undervoltage check
// RQ19 - Battery-short phase per channel, then discharge
// RQ20 - Coupling phase one on channel one
// RQ21 - Coupling phase two on channel two
// RQ22 - Phase times counted in clock cycles
module sist_selftest #(
	// Long phase length in cycles, shortened in simulation
	parameter int LONG_CYC = `SIST_T_LONG_US * `SIST_CLK_MHZ
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Analog monitor flags, asynchronous
	input wire logic [1:0] chan_undervolt,
	input wire logic [1:0] chan_battery_short,
	input wire logic [1:0] chan_ground_short,
	input wire logic vas_undervolt,
	input wire logic parity_fault,
	// Supply control
	output logic [1:0] chan_on,
	output logic vas_dis,
	output logic [1:0] discharge_pulldown,
	output logic short_mask,
	// Decoded sensor data from the receiver
	input wire logic rx_valid,
	input wire logic rx_chan,
	input wire logic [2:0] rx_slot,
	input wire logic [15:0] rx_data,
	input wire logic rx_crc_err,
	// Sync pulse triggering
	input wire logic [1:0] trigger_pin,
	input wire logic [1:0] ext_trig,
	input wire logic [1:0] up_bit,
	output logic [1:0] sync_pulse,
	output logic [1:0] rx_freeze,
	// Data outputs to the controller
	input wire logic [1:0] dout_in,
	output logic data_out_one,
	output logic data_out_two
);
	localparam int SHORT_CYC = `SIST_T_SHORT_US * `SIST_CLK_MHZ; // RQ22

	// One-hot of a channel index, used by drive and result logic
	function automatic logic [1:0] ch_bit(input logic c);
		ch_bit = c ? 2'h2 : 2'h1;
	endfunction : ch_bit

	// APB decode
	logic acc; // Access phase
	logic wr; // Write taken at this edge
	logic rd_acc; // Read taken at this edge
	logic setup; // Setup phase
	logic a_set, a_stat, a_chan, a_res, a_sr2, a_cmd, a_sid;
	logic [1:0] a_dat; // Data register hits
	logic hit; // Mapped address
	logic [31:0] rmux; // Read selection
	assign acc = psel & penable;
	assign wr = acc & pwrite;
	assign rd_acc = acc & ~pwrite;
	assign setup = psel & ~penable;
	assign a_set = paddr == `SIST_A_SET;
	assign a_stat = paddr == `SIST_A_STAT;
	assign a_chan = paddr == `SIST_A_CHAN;
	assign a_res = paddr == `SIST_A_RES;
	assign a_sr2 = paddr == `SIST_A_SR2;
	assign a_cmd = paddr == `SIST_A_CMD;
	assign a_dat = {paddr == `SIST_A_DAT2, paddr == `SIST_A_DAT1};
	assign a_sid = paddr[7:6] == `SIST_A_SID_PAGE && paddr[1:0] == 2'h0;
	assign hit = a_set | a_stat | a_chan | a_res | a_sr2 | a_cmd
		| (|a_dat) | a_sid;
	// No wait states; unmapped addresses answer with an error
	assign pready = 1'b1;
	assign pslverr = acc & ~hit;

	// Monitor flags through two flip-flops
	logic [7:0] meta; // First stage, read only by syn
	logic [7:0] syn; // Second stage
	logic [1:0] uv, stb, stg;
	logic diag; // Supply or parity fault
	assign uv = syn[1:0];
	assign stb = syn[3:2];
	assign stg = syn[5:4];
	assign diag = syn[6] | syn[7]; // RQ4
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta <= 8'h00;
			syn <= 8'h00;
		end else begin
			meta <= {parity_fault, vas_undervolt, chan_ground_short,
				chan_battery_short, chan_undervolt};
			syn <= meta;
		end
	end

	// Software-visible control
	logic out_test_level; // Static test level
	logic [4:0] out_test_select; // Output test selector
	logic [8:0] channel_control_reg; // On, supply off, method, buffer, pin
	logic st_mode; // Self-test mode entered
	logic [2:0] selftest_status_reg; // Empty test, force crc, force id
	logic be_test, force_crc, force_sid;
	assign be_test = selftest_status_reg[0];
	assign force_crc = selftest_status_reg[1];
	assign force_sid = selftest_status_reg[2];

	// Sequencer
	sist_pkg::sist_xct_state_t state, next_state;
	logic cur, next_cur; // Channel under test
	logic master; // Master mode run
	logic [1:0] excl; // Channels dropped after battery short
	logic [13:0] cnt; // Phase timer
	logic [13:0] ph_cnt; // Cycles spent in the state, checking only
	logic tdone; // Phase time over
	logic running;
	logic start_wr, start_ok, stop_wr, fin, ev;
	assign running = state != sist_pkg::ST_IDLE;
	assign tdone = cnt == 14'h0000;
	assign start_wr = wr & a_set & (pwdata[`SIST_B_GO_SLV]
		| pwdata[`SIST_B_GO_MST]);
	assign stop_wr = wr & a_set & pwdata[`SIST_B_STOP];
	// A busy channel refuses the start; a running test ignores it
	assign start_ok = start_wr & ~running
		& channel_control_reg[1:0] == 2'h0; // RQ12
	assign ev = tdone & ~stop_wr;

	// Next state of the cross-coupling sequence
	always_comb begin
		next_state = state;
		next_cur = cur;
		fin = 1'b0;
		case (state)
			sist_pkg::ST_IDLE: begin
				if (start_ok) begin
					next_cur = 1'b0;
					next_state = pwdata[`SIST_B_GO_MST] ?
						sist_pkg::ST_STB_ON : sist_pkg::ST_SLV_PD;
				end
			end
			sist_pkg::ST_SLV_PD: begin
				if (tdone) begin
					next_state = sist_pkg::ST_IDLE; // RQ18
					fin = 1'b1;
				end
			end
			sist_pkg::ST_STB_ON: begin
				if (tdone) begin
					next_state = sist_pkg::ST_STB_DIS; // RQ19
				end
			end
			sist_pkg::ST_STB_DIS: begin
				if (tdone && !cur) begin
					next_state = sist_pkg::ST_STB_ON; // RQ19
					next_cur = 1'b1;
				end else if (tdone && !excl[0]) begin
					next_state = sist_pkg::ST_X_ON; // RQ20
					next_cur = 1'b0;
				end else if (tdone && !excl[1]) begin
					next_state = sist_pkg::ST_X_ON; // RQ21
					next_cur = 1'b1;
				end else if (tdone) begin
					next_state = sist_pkg::ST_IDLE;
					fin = 1'b1;
				end
			end
			sist_pkg::ST_X_ON: begin
				if (tdone) begin
					next_state = sist_pkg::ST_X_DIS;
				end
			end
			sist_pkg::ST_X_DIS: begin
				if (tdone && !cur && !excl[1]) begin
					next_state = sist_pkg::ST_X_ON; // RQ21
					next_cur = 1'b1;
				end else if (tdone) begin
					next_state = sist_pkg::ST_IDLE; // RQ15
					fin = 1'b1;
				end
			end
			default: begin
				next_state = sist_pkg::ST_IDLE;
			end
		endcase
		// Only the stop bit ends a run early
		if (stop_wr && running) begin
			next_state = sist_pkg::ST_IDLE; // RQ14
			fin = 1'b0;
		end
	end

	// Phase lengths: powered and slave phases long, discharge short
	logic [13:0] load;
	assign load = (next_state == sist_pkg::ST_STB_DIS
		|| next_state == sist_pkg::ST_X_DIS) ?
		14'(SHORT_CYC - 1) : 14'(LONG_CYC - 1); // RQ22

	// State, channel and timer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= sist_pkg::ST_IDLE;
			cur <= 1'b0;
			cnt <= 14'h0000;
			ph_cnt <= 14'h0000;
		end else begin
			state <= next_state;
			cur <= next_cur;
			cnt <= (next_state != state) ? load : cnt - {13'h0, ~tdone};
			ph_cnt <= (next_state != state) ? 14'h0000 : ph_cnt + 14'h1;
		end
	end

	// Result flags: [0] done [1] aborted [3:2] slave or coupling pass
	// [5:4] battery short [7:6] ground short [8] master hold
	logic [8:0] flags, fset;
	logic clr; // Read of results or any start request
	logic [1:0] res_set, stb_set, stg_set;
	assign clr = (rd_acc & a_res) | start_wr; // RQ16
	// Slave passes a channel only if its undervoltage flag is clear
	assign res_set = (state == sist_pkg::ST_SLV_PD && ev) ? ~uv // RQ18
		: (state == sist_pkg::ST_X_ON && ev) ?
		ch_bit(~cur) & ~uv : 2'h0; // RQ20 RQ21
	assign stb_set = (state == sist_pkg::ST_STB_ON && ev) ?
		ch_bit(cur) & stb : 2'h0; // RQ19
	assign stg_set = (state == sist_pkg::ST_X_ON && ev) ?
		ch_bit(cur) & uv : 2'h0; // RQ20 RQ21
	assign fset = {fin & master, stg_set, stb_set, res_set,
		stop_wr & running & master, fin}; // RQ14 RQ15

	// Flags: a set in the clearing cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags <= 9'h000;
			master <= 1'b0;
			excl <= 2'h0;
		end else begin
			flags <= fset | (flags & ~{9{clr}}); // RQ16
			if (start_ok) begin
				master <= pwdata[`SIST_B_GO_MST];
				excl <= 2'h0;
			end else begin
				excl <= excl | stb_set; // RQ19
			end
		end
	end

	// Drive of supplies and pull-downs
	logic [1:0] test_on, test_pd;
	assign test_on = (state == sist_pkg::ST_STB_ON
		|| state == sist_pkg::ST_X_ON) ? ch_bit(cur) : 2'h0;
	assign test_pd = (state == sist_pkg::ST_SLV_PD) ? 2'h3 // RQ18
		: (state == sist_pkg::ST_STB_DIS || state == sist_pkg::ST_X_DIS)
		? ch_bit(cur) : 2'h0; // RQ19
	assign chan_on = running ? test_on : channel_control_reg[1:0];
	assign vas_dis = channel_control_reg[2];
	assign discharge_pulldown = test_pd;
	assign short_mask = |test_on; // RQ19

	// Ground-short view: live, or held master results
	logic [1:0] stg_v;
	assign stg_v = flags[8] ? flags[7:6] : stg; // RQ17

	// Control register writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_test_level <= 1'b0;
			out_test_select <= 5'h00;
			channel_control_reg <= `SIST_CHAN_RST;
			st_mode <= 1'b0;
			selftest_status_reg <= 3'h0;
		end else if (wr) begin
			if (a_set) begin
				out_test_level <= pwdata[`SIST_B_LEVEL];
				out_test_select <= pwdata[`SIST_B_SEL_HI:`SIST_B_SEL_LO];
			end
			// During a run, switch-on and supply-off writes are dropped
			if (a_chan) begin
				channel_control_reg <= {pwdata[8:3],
					running ? channel_control_reg[2] & pwdata[2] : pwdata[2],
					running ? channel_control_reg[1:0] & pwdata[1:0]
					: pwdata[1:0]}; // RQ13
			end
			if (a_cmd) begin
				st_mode <= (st_mode | pwdata[`SIST_B_ENTER])
					& ~pwdata[`SIST_B_LEAVE];
			end
			// Test bits can only be written inside self-test mode
			if (a_stat && st_mode) begin
				selftest_status_reg <= pwdata[2:0]; // RQ6
			end
		end
	end

	// Slot identity table and received data staging
	sist_sid_if sid_bus ();
	sist_sid_mem u_mem (
		.pclk(pclk),
		.presetn(presetn),
		.m(sid_bus.mem)
	);
	logic pend; // Word waits one cycle for its identity
	logic pend_chan;
	logic [15:0] pend_data;
	logic pend_crc;
	assign sid_bus.we = wr & a_sid; // RQ4
	assign sid_bus.waddr = paddr[5:2];
	assign sid_bus.wdata = pwdata[4:0];
	assign sid_bus.raddr = {rx_chan, rx_slot}; // RQ5

	// Receiver words are dropped while their channel is frozen
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend <= 1'b0;
			pend_chan <= 1'b0;
			pend_data <= 16'h0000;
			pend_crc <= 1'b0;
		end else begin
			pend <= rx_valid & ~rx_freeze[rx_chan]; // RQ2
			pend_chan <= rx_chan;
			pend_data <= rx_data;
			pend_crc <= rx_crc_err;
		end
	end

	// Sensor data buffers and the empty check
	logic [15:0] buf_data [2];
	logic [4:0] buf_sid [2];
	logic [1:0] buf_crc;
	logic [1:0] wr_new, rd_dat, chk;
	logic [1:0] buffer_empty_fault, be_set;
	assign wr_new = pend ? ch_bit(pend_chan) : 2'h0;
	assign rd_dat = rd_acc ? a_dat : 2'h0;
	assign be_set[0] = chk[0] & ~wr_new[0]
		& buf_data[0] != `SIST_EMPTY; // RQ7
	assign be_set[1] = chk[1] & ~wr_new[1]
		& buf_data[1] != `SIST_EMPTY; // RQ7
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 2; i++) begin
				buf_data[i] <= `SIST_EMPTY;
				buf_sid[i] <= 5'h00;
			end
			buf_crc <= 2'h0;
			chk <= 2'h0;
			buffer_empty_fault <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				// New data has priority; identity lands with it
				if (wr_new[i]) begin
					buf_data[i] <= pend_data; // RQ5
					buf_sid[i] <= sid_bus.rdata; // RQ4
					buf_crc[i] <= pend_crc;
				end else if (rd_dat[i] && !be_test) begin
					buf_data[i] <= `SIST_EMPTY; // RQ7 RQ8
				end
			end
			chk <= rd_dat & ~wr_new; // RQ7
			buffer_empty_fault <= be_set
				| (buffer_empty_fault & ~{2{rd_acc & a_sr2}});
		end
	end

	// Read data word of a channel, with forced faults
	logic [1:0] crc_v;
	logic [4:0] sid_v [2];
	assign crc_v = buf_crc | {2{force_crc}}; // RQ6
	assign sid_v[0] = buf_sid[0] ^ {4'h0, force_sid}; // RQ6
	assign sid_v[1] = buf_sid[1] ^ {4'h0, force_sid};

	// Read selection
	assign rmux = a_set ? {21'h0, out_test_level, out_test_select, 5'h00}
		: a_stat ? {29'h0, selftest_status_reg}
		: a_chan ? {23'h0, channel_control_reg}
		: a_res ? {22'h0, flags, running} // RQ15
		: a_sr2 ? {22'h0, buffer_empty_fault[1], stg_v[1], 6'h00,
			buffer_empty_fault[0], stg_v[0]} // RQ17
		: a_cmd ? {31'h0, st_mode}
		: a_dat[0] ? {9'h0, crc_v[0], diag, sid_v[0], buf_data[0]}
		: a_dat[1] ? {9'h0, crc_v[1], diag, sid_v[1], buf_data[1]}
		: 32'h0000_0000; // RQ4

	// Read data held from the setup phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup) begin
			prdata <= rmux;
		end
	end

	// Output test: the two codes exclude each other
	logic t1, t2;
	assign t1 = out_test_select == `SIST_SEL_OUT1; // RQ10 RQ11
	assign t2 = out_test_select == `SIST_SEL_OUT2; // RQ10 RQ11
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_out_one <= 1'b0;
			data_out_two <= 1'b0;
		end else begin
			data_out_one <= t1 ? out_test_level : dout_in[0]; // RQ9
			data_out_two <= t2 ? out_test_level : dout_in[1]; // RQ9
		end
	end

	// Sync pulse units, one per channel
	for (genvar g = 0; g < 2; g++) begin : g_sync
		sist_sync_pulse u_sync (
			.pclk(pclk),
			.presetn(presetn),
			.trig_pin(trigger_pin[g]),
			.ext_trig(ext_trig[g]),
			.pin_mode(channel_control_reg[7 + g]),
			.udb_en(channel_control_reg[5 + g]),
			.method_pw(channel_control_reg[3 + g]),
			.up_bit(up_bit[g]),
			.pulse(sync_pulse[g]),
			.freeze(rx_freeze[g])
		);
	end

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_bad_start;
		start_wr && !running && channel_control_reg[1:0] != 2'h0;
	endsequence
	sequence s_rd0;
		rd_dat[0] && !be_test && !wr_new[0];
	endsequence
	sequence s_keep0;
		(rd_dat[0] && be_test && !wr_new[0]
		&& buf_data[0] != `SIST_EMPTY) ##1 !wr_new[0];
	endsequence
	AST_NO_START: assert property (s_bad_start |=> // RQ12
		!running && flags == 9'h000) else $error("start not refused");
	AST_START_CLR: assert property (start_wr && !running |=> // RQ16
		flags[1:0] == 2'h0) else $error("results kept at start");
	AST_ON_LOCK: assert property (running && wr && a_chan |=> // RQ13
		(channel_control_reg[1:0] & ~$past(channel_control_reg[1:0]))
		== 2'h0) else $error("channel switched on in test");
	AST_ABORT: assert property (stop_wr && running && master |=> // RQ14
		!running && flags[1] && !flags[0]) else $error("bad abort");
	AST_DONE: assert property (fin |=> flags[0] && !running) // RQ15
		else $error("done not raised");
	AST_SLV_PD: assert property (state == sist_pkg::ST_IDLE // RQ18
		&& next_state == sist_pkg::ST_SLV_PD |=>
		discharge_pulldown == 2'h3 [*8]) else $error("pull-down off");
	AST_LONG_LEN: assert property (state == sist_pkg::ST_SLV_PD // RQ18
		&& next_state != state && !stop_wr |->
		ph_cnt == 14'(LONG_CYC - 1)) else $error("long phase length");
	AST_DIS_LEN: assert property (state == sist_pkg::ST_STB_DIS // RQ19
		&& next_state != state && !stop_wr |->
		ph_cnt == 14'(SHORT_CYC - 1)) else $error("discharge length");
	AST_EMPTY: assert property (s_rd0 |=> // RQ7
		buf_data[0] == `SIST_EMPTY) else $error("empty code missing");
	AST_KEEP: assert property (s_keep0 |=> buffer_empty_fault[0]) // RQ8
		else $error("buffer fault not raised");
	AST_DOUT: assert property (t1 |=> data_out_one == // RQ9
		$past(out_test_level) && data_out_two == $past(dout_in[1]))
		else $error("output test level wrong"); // RQ11
	AST_FREEZE: assert property (rx_valid && rx_freeze[rx_chan] // RQ2
		|=> !pend) else $error("data taken during pulse");
	AST_HOLD: assert property (flags[8] && !clr |=> flags[8] // RQ17
		&& $stable(flags[7:6]) && stg_v == flags[7:6])
		else $error("held result lost");
endmodule : sist_selftest
`default_nettype wire

// ### sist_line_model.sv
// Far-side model of the two sensor lines and their voltage monitors.
// Assumes chan_on comes from the block under test on pclk.
`timescale 1ns/100ps
`default_nettype none
module sist_line_model (
	// Supply control from the block
	input wire logic [1:0] chan_on,
	// Undervoltage flags back to the block
	output logic [1:0] uv
);
	// An unpowered line sags, so its undervoltage flag reads set
	assign uv = ~chan_on;
endmodule : sist_line_model
`default_nettype wire

// ### sist_selftest_tb.sv
// Self-checking bench for the sensor interface self-test block.
// Assumes the line model on the monitors; APB is driven from here.
`timescale 1ns/100ps
`default_nettype none
`include "sist_defs.svh"
module sist_selftest_tb;
	// Clock, reset and APB
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
	logic pwrite = 1'h0, pready, pslverr, perr, o1, o2, vd, sm;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, r;
	// Monitor, receiver and trigger stimulus
	logic vuv = 1'h0, par = 1'h0, rxv = 1'h0, rxc = 1'h0, crc = 1'h0;
	logic [1:0] uv, on, pd, sp, fz, bs = 2'h0, gs = 2'h0, trg = 2'h0;
	logic [1:0] ext = 2'h0, up = 2'h0, din = 2'h0;
	logic [2:0] slot = 3'h0;
	logic [15:0] rxd = 16'h0;
	int err_total = 0, n_tests = 0, cyc = 0;
	// Clock, 50 ns period
	always #25 pclk = ~pclk;
	sist_selftest #(.LONG_CYC(40)) u_dut (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .chan_undervolt(uv), .chan_battery_short(bs),
		.chan_ground_short(gs), .vas_undervolt(vuv), .parity_fault(par),
		.chan_on(on), .vas_dis(vd), .discharge_pulldown(pd),
		.short_mask(sm), .rx_valid(rxv), .rx_chan(rxc), .rx_slot(slot),
		.rx_data(rxd), .rx_crc_err(crc), .trigger_pin(trg),
		.ext_trig(ext), .up_bit(up), .sync_pulse(sp), .rx_freeze(fz),
		.dout_in(din), .data_out_one(o1), .data_out_two(o2));
	sist_line_model u_line (.chan_on(on), .uv(uv));
	// One APB transfer; only the hang guard ends a wait for pready
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		r = prdata;
		perr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		// Idle edge, so a next setup never reassigns psel at once
		@(posedge pclk);
	endtask : apb
	// Compare and count
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	// Verdict and end of run
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : test_done
	// Channel register default and an unmapped address
	task automatic t_regs;
		apb(1'h0, `SIST_A_CHAN, 32'h0);
		chk(r, 32'h180);
		apb(1'h0, 8'h20, 32'h0);
		chk({31'h0, perr}, 32'h1);
		chk(r, 32'h0);
	endtask : t_regs
	// Output test modes, one output at a time
	task automatic t_dout;
		apb(1'h1, `SIST_A_SET, 32'h6A0);
		repeat (2) @(posedge pclk);
		chk({o1, o2}, 2'h2);
		din <= 2'h3;
		apb(1'h1, `SIST_A_SET, 32'h2C0);
		repeat (2) @(posedge pclk);
		chk({o1, o2}, 2'h2);
		apb(1'h1, `SIST_A_SET, 32'h2E0);
		repeat (2) @(posedge pclk);
		chk({o1, o2}, 2'h3);
	endtask : t_dout
	// Slave test to completion, flags clear on read
	task automatic t_slave;
		apb(1'h1, `SIST_A_SET, 32'h800);
		apb(1'h0, `SIST_A_RES, 32'h0);
		chk(r, 32'h1);
		chk(pd, 2'h3);
		repeat (45) @(posedge pclk);
		apb(1'h0, `SIST_A_RES, 32'h0);
		chk(r, 32'h2);
		apb(1'h0, `SIST_A_RES, 32'h0);
		chk(r, 32'h0);
	endtask : t_slave
	// Refused start, ignored switch-on, slave abort
	task automatic t_guard;
		apb(1'h1, `SIST_A_CHAN, 32'h185);
		chk({29'h0, vd, on}, 32'h5);
		apb(1'h1, `SIST_A_SET, 32'h800);
		apb(1'h0, `SIST_A_RES, 32'h0);
		chk(r, 32'h0);
		apb(1'h1, `SIST_A_CHAN, 32'h180);
		apb(1'h1, `SIST_A_SET, 32'h800);
		apb(1'h1, `SIST_A_CHAN, 32'h185);
		chk({29'h0, vd, on}, 32'h0);
		apb(1'h0, `SIST_A_CHAN, 32'h0);
		chk(r, 32'h180);
		apb(1'h1, `SIST_A_SET, 32'h2000);
		apb(1'h0, `SIST_A_RES, 32'h0);
		chk(r, 32'h0);
	endtask : t_guard
	// Pin trigger starts a pulse that freezes the receiver
	task automatic t_sync;
		trg <= 2'h1;
		repeat (6) @(posedge pclk);
		chk({sp, fz}, 4'h5);
		trg <= 2'h0;
		repeat (100) @(posedge pclk);
		chk({sp, fz}, 4'h0);
	endtask : t_sync
	// Master abort, then a full master run with held results
	task automatic t_master;
		apb(1'h1, `SIST_A_SET, 32'h1000);
		chk({29'h0, sm, on}, 32'h5);
		apb(1'h1, `SIST_A_SET, 32'h2000);
		apb(1'h0, `SIST_A_RES, 32'h0);
		chk(r, 32'h4);
		apb(1'h1, `SIST_A_SET, 32'h1000);
		repeat (10420) @(posedge pclk);
		gs <= 2'h3;
		apb(1'h0, `SIST_A_SR2, 32'h0);
		chk(r, 32'h0);
		apb(1'h0, `SIST_A_RES, 32'h0);
		chk(r, 32'h202);
		apb(1'h0, `SIST_A_SR2, 32'h0);
		chk(r, 32'h101);
		gs <= 2'h0;
	endtask : t_master
	// Slot identity, diagnostic bit, forced faults, empty check
	task automatic t_data;
		apb(1'h1, `SIST_A_STAT, 32'h4);
		apb(1'h0, `SIST_A_STAT, 32'h0);
		chk(r, 32'h0);
		apb(1'h1, `SIST_A_CMD, 32'h1);
		apb(1'h1, 8'h48, 32'hB);
		vuv <= 1'h1;
		slot <= 3'h2;
		rxd <= 16'h1234;
		rxv <= 1'h1;
		@(posedge pclk);
		rxv <= 1'h0;
		@(posedge pclk);
		apb(1'h0, `SIST_A_DAT1, 32'h0);
		chk(r, 32'h002B1234);
		apb(1'h0, `SIST_A_DAT1, 32'h0);
		chk(r, 32'h002B01F0);
		apb(1'h1, `SIST_A_STAT, 32'h1);
		vuv <= 1'h0;
		rxd <= 16'h5555;
		rxv <= 1'h1;
		@(posedge pclk);
		rxv <= 1'h0;
		@(posedge pclk);
		apb(1'h0, `SIST_A_DAT1, 32'h0);
		chk(r, 32'h000B5555);
		apb(1'h0, `SIST_A_SR2, 32'h0);
		chk(r, 32'h2);
		apb(1'h1, `SIST_A_STAT, 32'h2);
		apb(1'h0, `SIST_A_DAT1, 32'h0);
		chk(r, 32'h004B5555);
		apb(1'h0, `SIST_A_SR2, 32'h0);
		chk(r, 32'h0);
	endtask : t_data
	// Hang guard
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 12000) begin
			err_total++;
			test_done;
		end
	end
	// Main sequence
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		t_regs;
		t_dout;
		t_slave;
		t_guard;
		t_sync;
		t_master;
		t_data;
		test_done;
	end
endmodule : sist_selftest_tb
`default_nettype wire
